// >>> hdl/trip_detector_defs.svh
/*
  Offsets, field positions and reset values of the supply trip detector
  control register. Assumes inclusion by bare name from hdl/.
*/
`ifndef TRIP_DETECTOR_DEFS_SVH
`define TRIP_DETECTOR_DEFS_SVH

`define VDC_ADDR_W 16
`define VDC_OFS_BASE 16'h2920
`define VDC_OFS_CLR 16'h2924
`define VDC_OFS_SET 16'h2928
`define VDC_OFS_INV 16'h292C
`define VDC_RESET 32'h0000_0000
`define VDC_BIT_ENABLE 15
`define VDC_BIT_STOP_IN_IDLE 13
`define VDC_BIT_DIR 11
`define VDC_BIT_BGSTABLE 10
`define VDC_BIT_IRSTABLE 9
`define VDC_BIT_EVENT 8
`define VDC_LEVEL_LSB 0
`define VDC_WRITE_MASK 32'h0000_A80F
`define VDC_LEVEL_EXTERNAL 4'hF
`define VDC_LEVEL_LOWEST 4'h5

`endif

// >>> hdl/trip_detector_pkg.sv
/*
  Types shared by the supply trip detector control block.
  Register constants stay in the defs header; state encodings are literals here.
*/
package trip_detector_pkg;

  typedef struct packed {
    logic enable;
    logic stop_in_idle;
    logic trip_direction_select;
    logic [3:0] trip_level_select;
  } ctrl_s;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ARMED = 3'b010,
    ST_EVENT = 3'b100
  } det_state_e;

endpackage

// >>> hdl/supply_trip_detector.sv
/*
  Control and status logic of a programmable supply-voltage trip detector.
  Assumes an analog comparator, band gap and internal reference outside,
  whose status lines are asynchronous, and a plain register port master.
*/
`timescale 1ns/1ns
`default_nettype none
`include "trip_detector_defs.svh"

// Behaviour
// - Detector runs only while the enable field is set.
// - Stop-in-idle set halts detection during Idle; cleared keeps it running.
// - Direction 1 flags voltage at or above trip; 0 at or below.
// - Interrupt flag set when voltage passes trip point in chosen direction.
// - Interrupt request forwarded; controller enable decides vectoring.
// - Read-only band gap stable flag follows reference stability.
// - Read-only internal reference stable flag; zero suppresses interrupt flag.
// - Read-only event status bit reads 1 while a crossing in the chosen direction persists.
// - Level code 1111 compares external sense input against band gap.
// - Codes 1110 to 0101 select ten rising supply trip windows.
// - Unimplemented control bits read as zero.
// - Clear, set and invert aliases at offsets 4, 8 and C.
// - All control fields reset to zero.
// - Idle stops the block only when its stop-in-idle field is set.
// - Module disable ignores writes and invalidates reads.
module supply_trip_detector (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [`VDC_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic idle_i,
  input wire logic module_disable_bit_i,
  input wire logic cmp_above_i,
  input wire logic cmp_below_i,
  input wire logic bandgap_stable_i,
  input wire logic internal_ref_stable_i,
  output logic analog_enable_o,
  output logic [3:0] trip_level_select_o,
  output logic external_sense_select_o,
  output logic irq_flag_o
);

  // ==========================================================
  // Register decode
  trip_detector_pkg::ctrl_s ctrl_r;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_nxt;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] rdata_r;
  logic hit_base, hit_clr, hit_set, hit_inv, hit_any;
  logic bg_sync_r, ir_sync_r, event_r;

  function automatic logic [31:0] pack_ctrl(input trip_detector_pkg::ctrl_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VDC_BIT_ENABLE] = c.enable;
    w[`VDC_BIT_STOP_IN_IDLE] = c.stop_in_idle;
    w[`VDC_BIT_DIR] = c.trip_direction_select;
    w[`VDC_LEVEL_LSB +: 4] = c.trip_level_select;
    return w;
  endfunction

  function automatic trip_detector_pkg::ctrl_s unpack_ctrl(input logic [31:0] w);
    trip_detector_pkg::ctrl_s c;
    c.enable = w[`VDC_BIT_ENABLE];
    c.stop_in_idle = w[`VDC_BIT_STOP_IN_IDLE];
    c.trip_direction_select = w[`VDC_BIT_DIR];
    c.trip_level_select = w[`VDC_LEVEL_LSB +: 4];
    return c;
  endfunction

  assign ctrl_word = pack_ctrl(ctrl_r);
  assign hit_base = (addr_i == `VDC_OFS_BASE);
  assign hit_clr = (addr_i == `VDC_OFS_CLR);
  assign hit_set = (addr_i == `VDC_OFS_SET);
  assign hit_inv = (addr_i == `VDC_OFS_INV);
  assign hit_any = hit_base | hit_clr | hit_set | hit_inv;

  assign ctrl_nxt = hit_base ? (wdata_i & `VDC_WRITE_MASK) :
                    hit_clr ? (ctrl_word & ~wdata_i) :
                    hit_set ? ((ctrl_word | wdata_i) & `VDC_WRITE_MASK) :
                    ((ctrl_word ^ wdata_i) & `VDC_WRITE_MASK);

  // Reset to zero; disabled block ignores writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= unpack_ctrl(`VDC_RESET);
    end else if (wr_i && hit_any && !module_disable_bit_i) begin
      ctrl_r <= unpack_ctrl(ctrl_nxt);
    end
  end

  always_comb begin
    status_word = ctrl_word;
    status_word[`VDC_BIT_BGSTABLE] = bg_sync_r;
    status_word[`VDC_BIT_IRSTABLE] = ir_sync_r;
    status_word[`VDC_BIT_EVENT] = event_r;
  end

  assign rd_word = (rd_i && hit_any && !module_disable_bit_i) ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rd_word;
    end
  end
  assign rdata_o = rdata_r;

  // ==========================================================
  // Input synchronisers
  logic [1:0] above_s1_r, above_s2_r;
  logic [1:0] ref_s1_r;
  logic above_sync, below_sync;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ref_s1_r <= 2'h0;
      bg_sync_r <= 1'b0;
      ir_sync_r <= 1'b0;
    end else begin
      ref_s1_r <= {internal_ref_stable_i, bandgap_stable_i};
      bg_sync_r <= ref_s1_r[0];
      ir_sync_r <= ref_s1_r[1];
    end
  end

  // Flush while unpowered
  // An unpowered comparator output is meaningless; keep it out of the sync chain
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !analog_enable_o) begin
      above_s1_r <= 2'h0;
      above_s2_r <= 2'h0;
    end else begin
      above_s1_r <= {cmp_below_i, cmp_above_i};
      above_s2_r <= above_s1_r;
    end
  end
  assign above_sync = above_s2_r[0];
  assign below_sync = above_s2_r[1];

  // ==========================================================
  // Detection
  trip_detector_pkg::det_state_e state_r, state_nxt;
  logic running, crossed, irq_r;

  // Run only when enabled and not halted by Idle
  assign running = ctrl_r.enable && !(idle_i && ctrl_r.stop_in_idle) && !module_disable_bit_i;
  assign analog_enable_o = ctrl_r.enable && !module_disable_bit_i;
  // Level code drives the analog trip selector
  assign trip_level_select_o = ctrl_r.trip_level_select;
  assign external_sense_select_o = (ctrl_r.trip_level_select == `VDC_LEVEL_EXTERNAL);
  assign crossed = ctrl_r.trip_direction_select ? above_sync : below_sync;

  always_comb begin
    case (state_r)
      trip_detector_pkg::ST_OFF: begin
        state_nxt = running ? trip_detector_pkg::ST_ARMED : trip_detector_pkg::ST_OFF;
      end
      trip_detector_pkg::ST_ARMED: begin
        if (!running) begin
          state_nxt = trip_detector_pkg::ST_OFF;
        end else if (crossed) begin
          state_nxt = trip_detector_pkg::ST_EVENT;
        end else begin
          state_nxt = trip_detector_pkg::ST_ARMED;
        end
      end
      trip_detector_pkg::ST_EVENT: begin
        if (!running) begin
          state_nxt = trip_detector_pkg::ST_OFF;
        end else if (!crossed) begin
          state_nxt = trip_detector_pkg::ST_ARMED;
        end else begin
          state_nxt = trip_detector_pkg::ST_EVENT;
        end
      end
      default: begin
        state_nxt = trip_detector_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= trip_detector_pkg::ST_OFF;
      event_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Event active while in detection state
      event_r <= (state_nxt == trip_detector_pkg::ST_EVENT);
      // One pulse per entry, gated by reference
      irq_r <= (state_r == trip_detector_pkg::ST_ARMED) &&
               (state_nxt == trip_detector_pkg::ST_EVENT) && ir_sync_r;
    end
  end
  assign irq_flag_o = irq_r;

  // ==========================================================
  // Assertions
  a_irq_single_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) irq_flag_o |=> !irq_flag_o)
    else $error("interrupt flag held longer than one cycle");

  a_irq_needs_ref: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) irq_flag_o |-> $past(ir_sync_r))
    else $error("interrupt flag raised with unstable reference");

  a_irq_sets_event: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) irq_flag_o |-> event_r)
    else $error("interrupt flag without active event");

  a_event_needs_enable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) !ctrl_r.enable |=> !event_r)
    else $error("event active while detector disabled");

  a_idle_halts: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (idle_i && ctrl_r.stop_in_idle) |=> !event_r)
    else $error("event active during idle halt");

  a_event_direction: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(event_r) |-> $past(ctrl_r.trip_direction_select ? above_sync : below_sync))
    else $error("event raised without crossing in chosen direction");

  a_read_reserved_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rdata_o[31:16] == 16'h0000) && !rdata_o[14] && !rdata_o[12] && (rdata_o[7:4] == 4'h0))
    else $error("unimplemented bits read non-zero");

  a_disable_no_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    module_disable_bit_i && wr_i |=> $stable(ctrl_r))
    else $error("write took effect while module disabled");

  a_set_alias: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && hit_set && !module_disable_bit_i && wdata_i[`VDC_BIT_ENABLE] |=> ctrl_r.enable)
    else $error("set alias did not set enable");

  a_bandgap_flag: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    bandgap_stable_i [*3] |-> bg_sync_r)
    else $error("band gap flag not following input");

  a_bandgap_low: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !bandgap_stable_i [*3] |-> !bg_sync_r)
    else $error("band gap flag set while reference unstable");

  a_clear_alias: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && hit_clr && !module_disable_bit_i && wdata_i[`VDC_BIT_ENABLE] |=> !ctrl_r.enable)
    else $error("clear alias did not clear enable");

  a_invert_alias: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && hit_inv && !module_disable_bit_i |=>
    (ctrl_word == (($past(ctrl_word) ^ $past(wdata_i)) & `VDC_WRITE_MASK)))
    else $error("invert alias did not toggle writable bits");

  a_reset_zero: assert property (
    @(posedge clk_i)
    !rst_n_i |=> (ctrl_word == `VDC_RESET) && !irq_flag_o && !event_r && (rdata_o == 32'h0000_0000))
    else $error("reset left a non-zero field");

  a_disable_read_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_i && module_disable_bit_i |=> (rdata_o == 32'h0000_0000))
    else $error("disabled block returned read data");

  a_irq_on_entry: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_r == trip_detector_pkg::ST_ARMED) && running && crossed && ir_sync_r |=> irq_flag_o)
    else $error("qualifying crossing raised no interrupt flag");

  a_event_clears: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    event_r && !crossed |=> !event_r)
    else $error("event status held after crossing went away");

  a_idle_no_irq: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (idle_i && ctrl_r.stop_in_idle) |=> !irq_flag_o)
    else $error("interrupt flag raised during idle halt");

  a_stale_flush: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !analog_enable_o |=> !above_sync && !below_sync)
    else $error("comparator history kept while unpowered");

endmodule
`default_nettype wire

// >>> verification/trip_analog_model.sv
/* Analog side model: trip comparator and reference flags.
   Assumes the bench sets the sensed level and reference health. */
`timescale 1ns/1ns
`default_nettype none
module trip_analog_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [3:0] level_i,
  input wire logic [7:0] volt_i,
  input wire logic ref_ok_i,
  output logic above_o,
  output logic below_o,
  output logic ref_stable_o
);
  logic [7:0] trip;
  logic tog_r = 1'h0;
  // Code F is band gap, lower codes trip higher
  assign trip = 8'hF0 - {1'h0, level_i, 3'h0};
  // Unpowered comparator output wanders
  always @(posedge clk_i) tog_r <= ~tog_r;
  assign above_o = en_i ? (volt_i >= trip) : tog_r;
  assign below_o = en_i ? (volt_i <= trip) : ~tog_r;
  assign ref_stable_o = en_i & ref_ok_i;
endmodule
`default_nettype wire

// >>> verification/tb.sv
/* Self-checking bench of the supply trip detector control block.
   Assumes the analog model and the defs header on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "trip_detector_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic idle = 1'h0;
  logic dis = 1'h0;
  logic ref_ok = 1'h0;
  logic [7:0] volt = 8'h10;
  logic rd_d = 1'h0;
  logic [31:0] rdata;
  logic above, below, ref_st, an_en, ext_sel, irq;
  logic [3:0] lvl;
  logic [31:0] exp_q[$];
  logic [31:0] d, exp_d;
  int bad_count = 0;
  int cmp_count = 0;
  int irq_n = 0;
  int cyc = 0;

  supply_trip_detector supply_trip_detector_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .idle_i(idle), .module_disable_bit_i(dis), .cmp_above_i(above),
    .cmp_below_i(below), .bandgap_stable_i(ref_st), .internal_ref_stable_i(ref_st),
    .analog_enable_o(an_en), .trip_level_select_o(lvl),
    .external_sense_select_o(ext_sel), .irq_flag_o(irq));
  trip_analog_model trip_analog_model_i (.clk_i(clk_i), .en_i(an_en), .level_i(lvl),
    .volt_i(volt), .ref_ok_i(ref_ok), .above_o(above), .below_o(below),
    .ref_stable_o(ref_st));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================
  // Output watcher
  always @(posedge clk_i) begin
    cyc++;
    if (rd_d && exp_q.size() > 0) begin
      exp_d = exp_q.pop_front();
      `CHK(rdata, exp_d)
    end
    rd_d <= rd;
    if (irq !== 1'h0) irq_n++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================
  // Bus tasks
  task automatic op(input logic w, input logic [15:0] a, input logic [31:0] x);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= x;
    if (!w) exp_q.push_back(x);
    @(posedge clk_i);
  endtask

  task automatic wait_cyc(input int n);
    wr <= 1'h0;
    rd <= 1'h0;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic det(input logic [15:0] cfg, input logic [7:0] v0, v1,
                     input logic ok, idl, ev);
    volt <= v0;
    ref_ok <= ok;
    idle <= idl;
    op(1'h1, `VDC_OFS_BASE, {16'h0, cfg});
    wait_cyc(6);
    irq_n = 0;
    volt <= v1;
    wait_cyc(8);
    `CHK(irq_n, int'(ev & ok))
    `CHK(an_en, cfg[15])
    `CHK(ext_sel, cfg[3:0] == 4'hF)
    op(1'h0, `VDC_OFS_BASE, {16'h0, cfg} | {21'h0, {2{ok & cfg[15]}}, ev, 8'h0});
    volt <= v0;
    op(1'h1, `VDC_OFS_CLR, 32'hFFFF_FFFF);
    wait_cyc(6);
    $display("detect test done cfg %h", cfg);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(59710));
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    // Reset value, masks and aliases back to back
    op(1'h0, `VDC_OFS_BASE, 32'h0);
    op(1'h0, 16'h2930, 32'h0);
    op(1'h1, `VDC_OFS_BASE, 32'hFFFF_FFFF);
    op(1'h0, `VDC_OFS_BASE, 32'h0000_A80F);
    op(1'h1, `VDC_OFS_CLR, 32'hFFFF_FFFF);
    op(1'h0, `VDC_OFS_BASE, 32'h0);
    op(1'h1, `VDC_OFS_SET, 32'h0000_2805);
    op(1'h1, `VDC_OFS_INV, 32'h0000_2003);
    op(1'h0, `VDC_OFS_BASE, 32'h0000_0806);
    for (int i = 0; i < 6; i++) begin
      d = $urandom() & 32'hFFFF_7FFF;
      if (d[3:0] < 4'h5) d[3:0] = 4'hE;
      op(1'h1, `VDC_OFS_BASE, d);
      op(1'h0, `VDC_OFS_BASE, d & 32'h0000_280F);
    end
    wait_cyc(3);
    $display("register test done");
    // Reference made stable before interrupts are relied on
    det(16'h880E, 8'h10, 8'h80, 1'h1, 1'h0, 1'h1);
    det(16'h800E, 8'hF0, 8'h80, 1'h1, 1'h0, 1'h1);
    det(16'h880F, 8'h10, 8'hF0, 1'h1, 1'h0, 1'h1);
    det(16'h8805, 8'h10, 8'hC0, 1'h1, 1'h0, 1'h0);
    det(16'h880E, 8'h10, 8'hF0, 1'h0, 1'h0, 1'h1);
    det(16'hA80E, 8'h10, 8'hF0, 1'h1, 1'h1, 1'h0);
    det(16'h880E, 8'h10, 8'hF0, 1'h1, 1'h1, 1'h1);
    det(16'h080E, 8'h10, 8'hF0, 1'h1, 1'h0, 1'h0);
    // Disabled block ignores writes and reads zero
    dis <= 1'h1;
    op(1'h1, `VDC_OFS_SET, 32'h0000_800E);
    op(1'h0, `VDC_OFS_BASE, 32'h0);
    wait_cyc(2);
    dis <= 1'h0;
    op(1'h0, `VDC_OFS_BASE, 32'h0);
    wait_cyc(3);
    `CHK(an_en, 1'h0)
    $display("disable test done");
    finish_test();
  end
endmodule
`default_nettype wire
